//--- verilog/radio_device.sv
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module radio_device #(
  parameter int OSC_CYC = radio_pkg::OSC_TIME_NS / radio_pkg::SYS_PERIOD_NS
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_b, // Power-on reset
  radio_link.dev link, // Link to host
  input wire logic rx_frame_start, // Frame detected pulse
  input wire logic rx_frame_end, // Frame received pulse
  output logic [4:0] state_code, // Current status code
  output logic pulls_en, // Input pulls active
  output logic synth_on, // Synthesizer powered
  output logic tx_active // Transmitting
);

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic sclk_p;
    logic slp_p;
    radio_pkg::dev_state_t st;
    radio_pkg::dev_state_t tgt;
    logic [15:0] tcnt;
    logic [15:0] ocnt;
    logic wake;
    logic [8:0] dcnt;
    logic clock_out_pin;
    logic [4:0] bits;
    logic [15:0] shi;
    logic [7:0] sho;
    logic miso;
    logic [2:0] rate;
    logic [7:0] mask;
    logic [7:0] irqs;
    logic pend;
    logic pulls;
  } dev_t;

  localparam logic [15:0] OSC16 = 16'(OSC_CYC);

  dev_t q;
  dev_t d;
  logic sleepy;
  logic osc_ok;
  logic [8:0] per;
  logic run;
  logic rise;
  logic fast;
  logic tick;
  logic spi_on;
  logic spi_rise;
  logic spi_fall;
  logic wr;
  logic cmd_v;
  logic rst_low;
  logic busy;
  logic go;
  logic [15:0] word;
  logic [4:0] cmd;
  logic [7:0] set;
  logic [7:0] clr;
  radio_pkg::dev_state_t nxt;
  logic [15:0] tload;

  always_comb begin
    d = q;
    set = 8'h00;
    clr = 8'h00;
    wr = 1'b0;
    cmd_v = 1'b0;
    go = 1'b0;
    nxt = radio_pkg::S_IDLE;
    tload = radio_pkg::TRANS_CYC;
    d.s1 = {link.cs_n, link.sclk, link.mosi, link.slp, link.rst_n};
    d.s2 = q.s1;
    d.sclk_p = q.s2[radio_pkg::SY_SCLK];
    d.slp_p = q.s2[radio_pkg::SY_SLP];
    rst_low = !q.s2[radio_pkg::SY_RST];
    sleepy = (q.st == radio_pkg::S_SLEEP) || (q.st == radio_pkg::S_DEEP);
    busy = (q.st == radio_pkg::S_BUSY_RX) || (q.st == radio_pkg::S_BUSY_TX);

    // Oscillator held off while asleep, restarts its settling count on wake
    osc_ok = (q.ocnt == 16'h0000);
    if (sleepy) begin
      d.ocnt = OSC16;
    end else if (!osc_ok) begin
      d.ocnt = q.ocnt - 16'h0001;
    end

    // Clock output divider
    per = radio_pkg::clock_out_pin_period(q.rate);
    run = osc_ok && !sleepy && (per != 9'h000);
    rise = run && (q.dcnt == per - 9'h001);
    fast = (q.rate == radio_pkg::RATE_1M);
    if (run) begin
      d.dcnt = rise ? 9'h000 : q.dcnt + 9'h001;
      d.clock_out_pin = (d.dcnt < (per >> 1));
    end else begin
      d.dcnt = 9'h000;
      d.clock_out_pin = 1'b0;
    end

    // Serial slave, only alive with a settled oscillator and awake
    spi_on = osc_ok && !sleepy && !q.s2[radio_pkg::SY_CS];
    spi_rise = spi_on && q.s2[radio_pkg::SY_SCLK] && !q.sclk_p;
    spi_fall = spi_on && !q.s2[radio_pkg::SY_SCLK] && q.sclk_p;
    word = {q.shi[14:0], q.s2[radio_pkg::SY_MOSI]};
    cmd = word[4:0];
    if (!spi_on) begin
      d.bits = 5'h00;
      d.miso = 1'b0;
    end else if (spi_rise) begin
      d.shi = word;
      d.bits = q.bits + 5'h01;
      if (q.bits == radio_pkg::LAST_ADDR_BIT) begin
        case (word[radio_pkg::ADDR_W-1:0])
          radio_pkg::A_STATUS: d.sho = {3'h0, radio_pkg::status_code(q.st)};
          radio_pkg::A_CLOCK_OUT_PIN: d.sho = {5'h00, q.rate};
          radio_pkg::A_MASK: d.sho = q.mask;
          radio_pkg::A_IRQ: d.sho = q.irqs;
          default: d.sho = 8'h00;
        endcase
        if (word[radio_pkg::ADDR_W-1:0] == radio_pkg::A_IRQ && !word[radio_pkg::DATA_HI]) begin
          clr = 8'hFF;
        end
      end
      if (q.bits == radio_pkg::LAST_BIT && word[radio_pkg::FRAME_RW]) begin
        wr = 1'b1;
      end
    end else if (spi_fall && q.bits > radio_pkg::LAST_ADDR_BIT) begin
      d.miso = q.sho[radio_pkg::DATA_HI];
      d.sho = {q.sho[6:0], 1'b0};
    end

    if (wr) begin
      case (word[radio_pkg::ADDR_HI:radio_pkg::ADDR_LO])
        radio_pkg::A_CMD: cmd_v = 1'b1;
        radio_pkg::A_CLOCK_OUT_PIN: d.rate = word[2:0];
        radio_pkg::A_MASK: d.mask = word[radio_pkg::DATA_HI:0];
        default: ;
      endcase
    end

    // Sleep entry with a fast clock output waits out clock cycles first
    tick = ((q.tgt == radio_pkg::S_SLEEP) || (q.tgt == radio_pkg::S_DEEP)) ? (!fast || rise) : osc_ok;

    case (q.st)
      radio_pkg::S_PON: begin
        if (cmd_v && (cmd == radio_pkg::C_IDLE || cmd == radio_pkg::C_FORCE_IDLE)) begin
          go = 1'b1;
          d.wake = 1'b1;
        end
      end
      radio_pkg::S_RESET: begin
        if (!rst_low) begin
          d.st = radio_pkg::S_IDLE;
          set[radio_pkg::IRQ_WAKE_DONE] = 1'b1;
        end
      end
      radio_pkg::S_IDLE: begin
        if (q.s2[radio_pkg::SY_SLP]) begin
          go = 1'b1;
          nxt = radio_pkg::S_SLEEP;
          tload = fast ? radio_pkg::SLEEP_CLOCK_OUT_PIN_CYC : radio_pkg::ONE_CYC;
        end
      end
      radio_pkg::S_SLEEP: begin
        if (!q.s2[radio_pkg::SY_SLP]) begin
          go = 1'b1;
          d.wake = 1'b1;
        end
      end
      radio_pkg::S_PREP: begin
        if (q.s2[radio_pkg::SY_SLP]) begin
          go = 1'b1;
          nxt = radio_pkg::S_DEEP;
          tload = fast ? radio_pkg::SLEEP_CLOCK_OUT_PIN_CYC : radio_pkg::ONE_CYC;
        end
      end
      radio_pkg::S_DEEP: begin
        if (!q.s2[radio_pkg::SY_SLP]) begin
          go = 1'b1;
          d.wake = 1'b1;
          d.rate = radio_pkg::RATE_1M;
          d.mask = 8'h00;
          d.irqs = 8'h00;
        end
      end
      radio_pkg::S_SYNTH: begin
        if (q.s2[radio_pkg::SY_SLP] && !q.slp_p) begin
          d.st = radio_pkg::S_BUSY_TX;
          d.tcnt = radio_pkg::TX_CYC;
        end
      end
      radio_pkg::S_RXON: begin
        if (rx_frame_start) begin
          d.st = radio_pkg::S_BUSY_RX;
        end
      end
      radio_pkg::S_BUSY_RX: begin
        if (rx_frame_end) begin
          d.st = radio_pkg::S_RXON;
          go = q.pend;
        end
      end
      radio_pkg::S_BUSY_TX: begin
        if (q.tcnt == radio_pkg::ONE_CYC) begin
          d.st = radio_pkg::S_SYNTH;
          go = q.pend;
        end else begin
          d.tcnt = q.tcnt - 16'h0001;
        end
      end
      radio_pkg::S_TRANS: begin
        if (tick) begin
          if (q.tcnt == radio_pkg::ONE_CYC) begin
            d.st = q.tgt;
            d.wake = 1'b0;
            set[radio_pkg::IRQ_WAKE_DONE] = q.wake && (q.tgt == radio_pkg::S_IDLE);
            set[radio_pkg::IRQ_SYNTH_LOCK] = (q.tgt == radio_pkg::S_SYNTH);
          end else begin
            d.tcnt = q.tcnt - 16'h0001;
          end
        end
      end
      default: d.st = radio_pkg::S_PON;
    endcase

    // Commands while in a transition are dropped; host must wait it out
    if (cmd_v && !go && q.st inside {radio_pkg::S_IDLE, radio_pkg::S_PREP, radio_pkg::S_SYNTH,
        radio_pkg::S_RXON, radio_pkg::S_BUSY_RX, radio_pkg::S_BUSY_TX}) begin
      case (cmd)
        radio_pkg::C_FORCE_IDLE: go = 1'b1;
        radio_pkg::C_IDLE: begin
          if (busy) begin
            d.pend = 1'b1;
          end else begin
            go = 1'b1;
          end
        end
        radio_pkg::C_FORCE_SYNTH: begin
          go = 1'b1;
          nxt = radio_pkg::S_SYNTH;
        end
        radio_pkg::C_SYNTH: begin
          go = (q.st == radio_pkg::S_IDLE) || (q.st == radio_pkg::S_RXON);
          nxt = radio_pkg::S_SYNTH;
        end
        radio_pkg::C_RX_ON: begin
          go = (q.st == radio_pkg::S_IDLE) || (q.st == radio_pkg::S_SYNTH);
          nxt = radio_pkg::S_RXON;
        end
        radio_pkg::C_PREP: begin
          go = (q.st == radio_pkg::S_IDLE);
          nxt = radio_pkg::S_PREP;
        end
        radio_pkg::C_TX_START: begin
          if (q.st == radio_pkg::S_SYNTH) begin
            d.st = radio_pkg::S_BUSY_TX;
            d.tcnt = radio_pkg::TX_CYC;
          end
        end
        default: ;
      endcase
    end

    if (go) begin
      d.st = radio_pkg::S_TRANS;
      d.tgt = nxt;
      d.tcnt = tload;
      d.pend = 1'b0;
    end

    // Event set wins over a read clear in the same cycle
    d.irqs = (d.irqs & ~clr) | (set & q.mask);

    // Reset pin outside deep sleep: registers back to defaults, clock rate shadowed
    if (rst_low && q.st != radio_pkg::S_DEEP) begin
      d.mask = 8'h00;
      d.irqs = 8'h00;
      d.pend = 1'b0;
      d.wake = 1'b0;
      if (q.st != radio_pkg::S_PON) begin
        d.st = radio_pkg::S_RESET;
      end
    end

    d.pulls = (d.st == radio_pkg::S_PON) || (d.st == radio_pkg::S_DEEP);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.ocnt <= OSC16;
      q.rate <= radio_pkg::RATE_1M;
      q.pulls <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.miso = q.miso;
  assign link.clock_out_pin = q.clock_out_pin;
  assign link.irq = |(q.irqs & q.mask);
  assign state_code = radio_pkg::status_code(q.st);
  assign pulls_en = q.pulls;
  assign tx_active = (q.st == radio_pkg::S_BUSY_TX);
  assign synth_on = (q.st inside {radio_pkg::S_SYNTH, radio_pkg::S_RXON, radio_pkg::S_BUSY_RX, radio_pkg::S_BUSY_TX})
    || (q.st == radio_pkg::S_TRANS && q.tgt inside {radio_pkg::S_SYNTH, radio_pkg::S_RXON});

endmodule : radio_device

//--- verilog/radio_pkg.sv
package radio_pkg;
  // Timing
  localparam int SYS_PERIOD_NS = 40;
  localparam int OSC_TIME_NS = 330000;
  localparam int TRANS_TIME_NS = 1000;
  localparam int TX_TIME_NS = 16000;
  localparam int CLOCK_OUT_PIN_1M_NS = 1000;
  localparam int CLOCK_OUT_PIN_250K_NS = 4000;
  localparam int CLOCK_OUT_PIN_62K_NS = 16000;
  localparam logic [15:0] TRANS_CYC = 16'((TRANS_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
  localparam logic [15:0] TX_CYC = 16'((TX_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
  localparam logic [8:0] CLOCK_OUT_PIN_PER_1M = 9'(CLOCK_OUT_PIN_1M_NS / SYS_PERIOD_NS);
  localparam logic [8:0] CLOCK_OUT_PIN_PER_250K = 9'(CLOCK_OUT_PIN_250K_NS / SYS_PERIOD_NS);
  localparam logic [8:0] CLOCK_OUT_PIN_PER_62K = 9'(CLOCK_OUT_PIN_62K_NS / SYS_PERIOD_NS);
  localparam logic [15:0] SLEEP_CLOCK_OUT_PIN_CYC = 16'h0023;
  localparam logic [15:0] ONE_CYC = 16'h0001;
  // Serial frame: rw flag, 7-bit address, 8-bit data, msb first
  localparam int FRAME_RW = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 8;
  localparam int DATA_HI = 7;
  localparam int ADDR_W = 7;
  localparam logic [4:0] LAST_ADDR_BIT = 5'h07;
  localparam logic [4:0] LAST_BIT = 5'h0F;
  localparam logic [4:0] SPI_HALF_CYC = 5'h0A;
  // Device register addresses
  localparam logic [6:0] A_STATUS = 7'h01;
  localparam logic [6:0] A_CMD = 7'h02;
  localparam logic [6:0] A_CLOCK_OUT_PIN = 7'h03;
  localparam logic [6:0] A_MASK = 7'h0E;
  localparam logic [6:0] A_IRQ = 7'h0F;
  // Command codes
  localparam logic [4:0] C_TX_START = 5'h02;
  localparam logic [4:0] C_FORCE_IDLE = 5'h03;
  localparam logic [4:0] C_FORCE_SYNTH = 5'h04;
  localparam logic [4:0] C_RX_ON = 5'h06;
  localparam logic [4:0] C_IDLE = 5'h08;
  localparam logic [4:0] C_SYNTH = 5'h09;
  localparam logic [4:0] C_PREP = 5'h10;
  // Status codes
  localparam logic [4:0] S_PON_CODE = 5'h00;
  localparam logic [4:0] S_BUSY_RX_CODE = 5'h01;
  localparam logic [4:0] S_BUSY_TX_CODE = 5'h02;
  localparam logic [4:0] S_RXON_CODE = 5'h06;
  localparam logic [4:0] S_IDLE_CODE = 5'h08;
  localparam logic [4:0] S_SYNTH_CODE = 5'h09;
  localparam logic [4:0] S_SLEEP_CODE = 5'h0F;
  localparam logic [4:0] S_PREP_CODE = 5'h10;
  localparam logic [4:0] TRANSITION_PENDING_CODE = 5'h1F;
  // Clock output rate field
  localparam logic [2:0] RATE_OFF = 3'h0;
  localparam logic [2:0] RATE_1M = 3'h1;
  localparam logic [2:0] RATE_250K = 3'h5;
  localparam logic [2:0] RATE_62K = 3'h6;
  // Interrupt bits
  localparam int IRQ_SYNTH_LOCK = 0;
  localparam int IRQ_WAKE_DONE = 4;
  // Sync vector positions in the device
  localparam int SY_CS = 4;
  localparam int SY_SCLK = 3;
  localparam int SY_MOSI = 2;
  localparam int SY_SLP = 1;
  localparam int SY_RST = 0;
  // Host register byte addresses
  localparam logic [3:0] H_CTRL = 4'h0;
  localparam logic [3:0] H_XFER = 4'h4;
  localparam logic [3:0] H_STAT = 4'h8;
  localparam int H_CTRL_SLP = 0;
  localparam int H_CTRL_RST = 1;

  typedef enum logic [3:0] {
    S_PON, S_RESET, S_IDLE, S_SLEEP, S_PREP, S_DEEP, S_SYNTH, S_RXON, S_BUSY_RX, S_BUSY_TX, S_TRANS
  } dev_state_t;

  function automatic logic [4:0] status_code(input dev_state_t s);
    case (s)
      S_PON: status_code = S_PON_CODE;
      S_IDLE: status_code = S_IDLE_CODE;
      S_SLEEP: status_code = S_SLEEP_CODE;
      S_PREP: status_code = S_PREP_CODE;
      S_SYNTH: status_code = S_SYNTH_CODE;
      S_RXON: status_code = S_RXON_CODE;
      S_BUSY_RX: status_code = S_BUSY_RX_CODE;
      S_BUSY_TX: status_code = S_BUSY_TX_CODE;
      default: status_code = TRANSITION_PENDING_CODE;
    endcase
  endfunction : status_code

  function automatic logic [8:0] clock_out_pin_period(input logic [2:0] r);
    case (r)
      RATE_1M: clock_out_pin_period = CLOCK_OUT_PIN_PER_1M;
      RATE_250K: clock_out_pin_period = CLOCK_OUT_PIN_PER_250K;
      RATE_62K: clock_out_pin_period = CLOCK_OUT_PIN_PER_62K;
      default: clock_out_pin_period = 9'h000;
    endcase
  endfunction : clock_out_pin_period
endpackage : radio_pkg

//--- verilog/radio_link.sv
`timescale 1ns/1ns
interface radio_link;
  logic sclk;
  logic mosi;
  logic miso;
  logic cs_n;
  logic slp;
  logic rst_n;
  logic clock_out_pin;
  logic irq;
  modport dev (input sclk, mosi, cs_n, slp, rst_n, output miso, clock_out_pin, irq);
  modport host (output sclk, mosi, cs_n, slp, rst_n, input miso, clock_out_pin, irq);
endinterface : radio_link

//--- verilog/radio_host.sv
`timescale 1ns/1ns
module radio_host (
  input wire logic sys_clk, // System clock
  input wire logic rst_b, // Reset
  input wire logic [3:0] addr, // Register byte address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after rd
  radio_link.host link // Link to device
);

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic clock_out_pin_p;
    logic seen;
    logic busy;
    logic [4:0] div;
    logic [4:0] bits;
    logic [15:0] sh;
    logic [7:0] rx;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic slp;
    logic rst_n;
    logic rdst;
    logic [7:0] last;
    logic refused;
    logic [31:0] rdata;
  } host_t;

  host_t q;
  host_t d;
  logic is_cmd;
  logic [15:0] frame;

  always_comb begin
    d = q;
    d.s1 = {link.irq, link.clock_out_pin, link.miso};
    d.s2 = q.s1;
    d.clock_out_pin_p = q.s2[1];
    frame = wdata[15:0];
    is_cmd = frame[radio_pkg::FRAME_RW] && (frame[radio_pkg::ADDR_HI:radio_pkg::ADDR_LO] == radio_pkg::A_CMD);
    if (q.s2[1] && !q.clock_out_pin_p) begin
      d.seen = 1'b1;
    end

    d.rdata = 32'h0000_0000;
    if (rd) begin
      case (addr)
        radio_pkg::H_CTRL: d.rdata = {30'h0, q.rst_n, q.slp};
        radio_pkg::H_STAT: d.rdata = {20'h0, q.refused, q.s2[2], q.seen, q.busy, q.rx};
        default: d.rdata = 32'h0000_0000;
      endcase
    end

    if (wr && addr == radio_pkg::H_CTRL) begin
      d.slp = wdata[radio_pkg::H_CTRL_SLP];
      d.rst_n = wdata[radio_pkg::H_CTRL_RST];
    end

    if (wr && addr == radio_pkg::H_XFER) begin
      // No access before the device clock runs, no command while the last status read showed a transition pending
      if (q.busy || !q.seen || (is_cmd && q.last[4:0] == radio_pkg::TRANSITION_PENDING_CODE)) begin
        d.refused = 1'b1;
      end else begin
        d.refused = 1'b0;
        d.busy = 1'b1;
        d.sh = frame;
        d.cs_n = 1'b0;
        d.sclk = 1'b0;
        d.mosi = frame[radio_pkg::FRAME_RW];
        d.div = radio_pkg::SPI_HALF_CYC - 5'h01;
        d.bits = 5'h00;
        d.rdst = !frame[radio_pkg::FRAME_RW] && (frame[radio_pkg::ADDR_HI:radio_pkg::ADDR_LO] == radio_pkg::A_STATUS);
        if (is_cmd && (frame[4:0] == radio_pkg::C_FORCE_IDLE || frame[4:0] == radio_pkg::C_FORCE_SYNTH)) begin
          d.slp = 1'b0;
        end
      end
    end else if (q.busy) begin
      if (q.div != 5'h00) begin
        d.div = q.div - 5'h01;
      end else begin
        d.div = radio_pkg::SPI_HALF_CYC - 5'h01;
        if (!q.sclk) begin
          d.sclk = 1'b1;
          d.rx = {q.rx[6:0], q.s2[0]};
        end else begin
          d.sclk = 1'b0;
          if (q.bits == radio_pkg::LAST_BIT) begin
            d.busy = 1'b0;
            d.cs_n = 1'b1;
            if (q.rdst) begin
              d.last = q.rx;
            end
          end else begin
            d.bits = q.bits + 5'h01;
            d.sh = {q.sh[14:0], 1'b0};
            d.mosi = q.sh[14];
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.cs_n <= 1'b1;
      q.rst_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.sclk = q.sclk;
  assign link.mosi = q.mosi;
  assign link.cs_n = q.cs_n;
  assign link.slp = q.slp;
  assign link.rst_n = q.rst_n;
  assign rdata = q.rdata;

endmodule : radio_host

//--- testbench/radio_state_controller_asserts.sv
`timescale 1ns/1ns
module radio_state_controller_asserts (
  input wire logic sys_clk, // System clock
  input wire logic rst_b, // Reset, active low
  input wire logic sclk, // Serial clock
  input wire logic mosi, // Host data
  input wire logic miso, // Device data
  input wire logic cs_n, // Select, active low
  input wire logic slp, // Sleep/transmit pin
  input wire logic rst_n, // Device reset pin
  input wire logic clock_out_pin, // Clock output
  input wire logic irq // Interrupt
);
  logic sclk_q;
  logic clock_out_pin_q;
  logic seen_q;
  logic [4:0] rises_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // Rises counted per frame, cleared between frames
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      clock_out_pin_q <= 1'b0;
      seen_q <= 1'b0;
      rises_q <= 5'h00;
    end else begin
      sclk_q <= sclk;
      clock_out_pin_q <= clock_out_pin;
      seen_q <= seen_q | (clock_out_pin & ~clock_out_pin_q);
      rises_q <= cs_n ? 5'h00 : rises_q + 5'(sclk & ~sclk_q);
    end
  end

  sequence lead_s;
    (!cs_n && !sclk) [*8];
  endsequence
  sequence quiet_s;
    cs_n [*6];
  endsequence

  port_default_a: assert property ($rose(rst_b) |-> cs_n && rst_n && !slp)
    else $error("pins not at default after reset");
  osc_wait_a: assert property ($rose(rst_b) |-> (!clock_out_pin) [*8])
    else $error("clock output before oscillator settled");
  access_gate_a: assert property ($fell(cs_n) |-> seen_q)
    else $error("frame before clock output seen");
  frame_lead_a: assert property ($fell(cs_n) |-> lead_s)
    else $error("serial clock too soon after select");
  frame_len_a: assert property ($rose(cs_n) |-> rises_q == 5'h10)
    else $error("frame not sixteen bits");
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("serial clock moves while deselected");
  mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("host data moved while clock high");
  miso_idle_a: assert property (quiet_s |-> !miso)
    else $error("device data not idle");
  rst_irq_a: assert property ($fell(rst_n) |-> ##[1:6] !irq)
    else $error("interrupt survives reset pin");
endmodule : radio_state_controller_asserts

//--- testbench/radio_state_controller_test.sv
`timescale 1ns/1ns
module radio_state_controller_test;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rx_frame_start = 1'b0;
  logic rx_frame_end = 1'b0;
  logic [31:0] rdata;
  logic [4:0] state_code;
  logic pulls_en;
  logic synth_on;
  logic tx_active;
  logic [31:0] rv;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;

  radio_link link();
  radio_device #(.OSC_CYC(20)) radio_device_inst (.sys_clk(sys_clk), .rst_b(rst_b), .link(link),
    .rx_frame_start(rx_frame_start), .rx_frame_end(rx_frame_end), .state_code(state_code),
    .pulls_en(pulls_en), .synth_on(synth_on), .tx_active(tx_active));
  radio_host radio_host_inst (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .link(link));
  radio_state_controller_asserts radio_state_controller_asserts_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso), .cs_n(link.cs_n), .slp(link.slp),
    .rst_n(link.rst_n), .clock_out_pin(link.clock_out_pin), .irq(link.irq));

  always #20 sys_clk = ~sys_clk;

  // Hang guard, well above the expected run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic bus(input logic [3:0] a, input logic [31:0] d, input logic w);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge sys_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 rv = rdata;
  endtask : bus

  // Poll busy; a refused transfer never shows busy
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
    bus(radio_pkg::H_XFER, {16'h0000, w, a, d}, 1'b1);
    rv = 32'h0000_0100;
    for (int i = 0; i < 300 && rv[8] !== 1'b0; i++)
      bus(radio_pkg::H_STAT, 32'h0000_0000, 1'b0);
  endtask : xfer

  task automatic cmd(input logic [4:0] c);
    xfer(1'b1, radio_pkg::A_CMD, {3'h0, c});
  endtask : cmd

  task automatic rreg(input string n, input logic [6:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(n, e, rv[7:0]);
  endtask : rreg

  task automatic ctrl(input logic [1:0] v);
    bus(radio_pkg::H_CTRL, {30'h0, v}, 1'b1);
  endtask : ctrl

  task automatic wcode(input logic [4:0] c);
    for (int i = 0; i < 2000 && state_code !== c; i++)
      @(posedge sys_clk);
    chk("state", {3'h0, c}, {3'h0, state_code});
  endtask : wcode

  // Raise sleep pin just after a clock output rise, then count rises
  task automatic sleep_clk(input logic [7:0] e, input logic [4:0] c);
    int n;
    logic p;
    n = 0;
    p = 1'b1;
    @(posedge link.clock_out_pin);
    ctrl(2'b11);
    repeat (1200) begin
      @(posedge sys_clk);
      if (link.clock_out_pin && !p)
        n++;
      p = link.clock_out_pin;
    end
    chk("clock_out_pin_rises", e, n[7:0]);
    chk("state", {3'h0, c}, {3'h0, state_code});
  endtask : sleep_clk

  task automatic busy_rx;
    cmd(radio_pkg::C_RX_ON);
    wcode(radio_pkg::S_RXON_CODE);
    @(posedge sys_clk);
    rx_frame_start <= 1'b1;
    @(posedge sys_clk);
    rx_frame_start <= 1'b0;
    wcode(radio_pkg::S_BUSY_RX_CODE);
  endtask : busy_rx

  task automatic t_power_on;
    bus(radio_pkg::H_XFER, 32'h0000_0100, 1'b1);
    bus(radio_pkg::H_STAT, 32'h0000_0000, 1'b0);
    chk("refused", 8'h01, {7'h0, rv[11]});
    chk("state", 8'h00, {3'h0, state_code});
    chk("pulls", 8'h01, {7'h0, pulls_en});
    @(posedge link.clock_out_pin);
    // Host sees the clock only after its two sync flops
    repeat (4) @(posedge sys_clk);
    rreg("status", radio_pkg::A_STATUS, 8'h00);
    $display("power-on test done");
  endtask : t_power_on

  task automatic t_wake;
    xfer(1'b1, radio_pkg::A_MASK, 8'h11);
    cmd(radio_pkg::C_IDLE);
    chk("state", 8'h1F, {3'h0, state_code});
    wcode(radio_pkg::S_IDLE_CODE);
    chk("pulls", 8'h00, {7'h0, pulls_en});
    rreg("status", radio_pkg::A_STATUS, 8'h08);
    chk("irq", 8'h01, {7'h0, link.irq});
    rreg("irq_status", radio_pkg::A_IRQ, 8'h10);
    chk("irq", 8'h00, {7'h0, link.irq});
    $display("wake test done");
  endtask : t_wake

  task automatic t_sleep;
    sleep_clk(8'd35, radio_pkg::S_SLEEP_CODE);
    ctrl(2'b10);
    wcode(radio_pkg::S_IDLE_CODE);
    rreg("mask", radio_pkg::A_MASK, 8'h11);
    $display("sleep test done");
  endtask : t_sleep

  task automatic t_reset_pin;
    xfer(1'b1, radio_pkg::A_CLOCK_OUT_PIN, {5'h0, radio_pkg::RATE_250K});
    sleep_clk(8'd0, radio_pkg::S_SLEEP_CODE);
    ctrl(2'b00);
    wcode(radio_pkg::TRANSITION_PENDING_CODE);
    // Oscillator restarts on leaving sleep; serial port dead until settled
    repeat (30) @(posedge sys_clk);
    rreg("status", radio_pkg::A_STATUS, 8'h1F);
    bus(radio_pkg::H_XFER, {16'h0000, 1'b1, radio_pkg::A_CMD, 8'h08}, 1'b1);
    bus(radio_pkg::H_STAT, 32'h0000_0000, 1'b0);
    chk("refused", 8'h01, {7'h0, rv[11]});
    ctrl(2'b10);
    wcode(radio_pkg::S_IDLE_CODE);
    @(posedge link.clock_out_pin);
    repeat (4) @(posedge sys_clk);
    rreg("status", radio_pkg::A_STATUS, 8'h08);
    rreg("mask", radio_pkg::A_MASK, 8'h00);
    rreg("rate", radio_pkg::A_CLOCK_OUT_PIN, 8'h05);
    $display("reset pin test done");
  endtask : t_reset_pin

  task automatic t_tx;
    cmd(radio_pkg::C_SYNTH);
    wcode(radio_pkg::S_SYNTH_CODE);
    chk("synth_on", 8'h01, {7'h0, synth_on});
    ctrl(2'b11);
    wcode(radio_pkg::S_BUSY_TX_CODE);
    chk("tx_active", 8'h01, {7'h0, tx_active});
    ctrl(2'b10);
    cmd(radio_pkg::C_IDLE);
    chk("state", 8'h02, {3'h0, state_code});
    wcode(radio_pkg::S_IDLE_CODE);
    $display("transmit test done");
  endtask : t_tx

  task automatic t_force;
    cmd(radio_pkg::C_SYNTH);
    wcode(radio_pkg::S_SYNTH_CODE);
    busy_rx();
    cmd(radio_pkg::C_FORCE_SYNTH);
    wcode(radio_pkg::S_SYNTH_CODE);
    chk("synth_on", 8'h01, {7'h0, synth_on});
    busy_rx();
    cmd(radio_pkg::C_IDLE);
    chk("state", 8'h01, {3'h0, state_code});
    @(posedge sys_clk);
    rx_frame_end <= 1'b1;
    @(posedge sys_clk);
    rx_frame_end <= 1'b0;
    wcode(radio_pkg::S_IDLE_CODE);
    cmd(radio_pkg::C_SYNTH);
    wcode(radio_pkg::S_SYNTH_CODE);
    busy_rx();
    cmd(radio_pkg::C_FORCE_IDLE);
    wcode(radio_pkg::S_IDLE_CODE);
    chk("synth_on", 8'h00, {7'h0, synth_on});
    $display("forced command test done");
  endtask : t_force

  task automatic t_deep;
    cmd(radio_pkg::C_PREP);
    wcode(radio_pkg::S_PREP_CODE);
    sleep_clk(8'd0, radio_pkg::TRANSITION_PENDING_CODE);
    chk("pulls", 8'h01, {7'h0, pulls_en});
    ctrl(2'b10);
    wcode(radio_pkg::S_IDLE_CODE);
    rreg("rate", radio_pkg::A_CLOCK_OUT_PIN, 8'h01);
    $display("deep sleep test done");
  endtask : t_deep

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_power_on();
    t_wake();
    t_sleep();
    t_reset_pin();
    t_tx();
    t_force();
    t_deep();
    summarize();
  end
endmodule : radio_state_controller_test
